/* File: include/audio_router_pkg.sv */
package audio_router_pkg;
    localparam int SW   = 24;
    localparam int NCH  = 8;
    localparam int NEMB = 16;
    typedef logic signed [SW-1:0] sample_t;
    typedef sample_t [NEMB-1:0]   emb_frame_t;
    typedef sample_t [NCH-1:0]    ana_frame_t;
    typedef sample_t [1:0]        pair_t;

    localparam logic [1:0] MODE_MUX4  = 2'h0;
    localparam logic [1:0] MODE_MUX8  = 2'h1;
    localparam logic [1:0] MODE_DEMUX = 2'h2;
    localparam logic [2:0] GRP_OFF    = 3'h4;
    localparam logic [2:0] STAT_NONE  = 3'h0;
    localparam logic [2:0] STAT_OFF   = 3'h5;

    localparam logic [7:0] A_CONFIG  = 8'h00;
    localparam logic [7:0] A_DELAY   = 8'h04;
    localparam logic [7:0] A_STATUS  = 8'h08;
    localparam logic [7:0] A_MONITOR = 8'h0c;
    localparam logic [7:0] A_LINK    = 8'h10;
    localparam logic [7:0] A_METER_A = 8'h14;
    localparam logic [7:0] A_METER_B = 8'h18;
    localparam logic [2:0] A_GAIN_HI = 3'h1;
    localparam int CFG_MODE = 0;
    localparam int CFG_DREF = 2;
    localparam int CFG_PEAK = 4;
    localparam int CFG_AREF = 7;
    localparam int CFG_GRPA = 8;
    localparam int CFG_GRPB = 12;
    localparam int MON_PAIR = 0;
    localparam int MON_VOL  = 8;
    localparam int MON_DISP = 16;
    localparam int LNK_TIE  = 0;
    localparam int LNK_INV  = 8;
    localparam int GN_ROUTE = 8;

    localparam logic [6:0]      MON_VOL_RST  = 7'h64;
    localparam logic [9:0]      DELAY_MAX_MS = 10'h3e8;
    localparam logic [7:0][7:0] ROUTE_RST    = 64'h8040201008040201;
    localparam int GAIN_MIN_DB = -70;
    localparam int GAIN_MAX_DB = 12;
    localparam logic [10:0] VOL_MUL = 11'h51e;
    localparam int VOL_SHIFT = 17;
    localparam logic [5:0][16:0] GAIN_TAB = {17'h1c824, 17'h19660, 17'h16a0a,
                                             17'h1428a, 17'h11f5a, 17'h10000};
    localparam logic [5:0][22:0] PEAK_THR = {23'h287a26, 23'h32f52c, 23'h40279a,
                                             23'h50a3d7, 23'h65ac8b, 23'h7ffffe};
    localparam logic [1:0][22:0] VU_ORANGE = {23'h101dc0, 23'h0ccccd};
    localparam logic [1:0][22:0] VU_GREEN  = {23'h019c93, 23'h0147ae};
    localparam int DLY_AW = 16;
    localparam int MET_W  = 16;

    typedef enum logic [1:0] {MS_IDLE, MS_LOAD, MS_MIX, MS_OUT} mix_state_t;

    typedef struct packed {
        logic aw_have, w_have, awready, wready, bvalid, arready, rvalid;
        logic [7:0] awaddr;
        logic [31:0] wdata, rdata;
        logic [3:0] wstrb;
        logic [1:0] bresp, rresp;
        logic [1:0] mode;
        logic dig_ref, ana_ref;
        logic [2:0] peak_sel, grp_b, mon_pair, disp_pair;
        logic [1:0] grp_a;
        logic [9:0] delay_ms;
        logic [6:0] mon_vol;
        logic [3:0] tie;
        logic [7:0] invert, peak, vu_grn, vu_org, ana_dir;
        logic [7:0][7:0] gain, route;
        mix_state_t st;
        logic [2:0] bi, ii;
        logic signed [31:0] acc;
        ana_frame_t src, bus, ana_out;
        emb_frame_t emb, emb_out;
        logic [DLY_AW-1:0] wptr;
        logic [MET_W-1:0] mcnt;
        logic [7:0][22:0] vmax;
        pair_t mon, disp;
        logic out_valid, in_ready, ana_ref_hi;
    } state_t;
endpackage

/* File: logic/audio_port_mux_mixer_router.sv */
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Overview of operation
// - Eight analog ports run as 4-in/4-out, 8-in or 8-out per port mode.
// - Digital reference level picks -20 or -18 dBFS as 0 VU.
// - Peak threshold is clipping or 2, 4, 6, 8, 10 dB headroom.
// - Analog reference level is -10 dBu or +4 dBu for the ports.
// - Audio delay is programmable 0 to 1000 ms, zero after reset.
// - Eight-in mode embeds into group A (1-4) and group B (1-4 or off).
// - Four-in/four-out mode embeds into group A only.
// - Eight-out mode extracts group A and optional group B to analog outputs.
// - Each slot reports no audio or group OK; slot B also reports off.
// - Per-channel peak flag when output level exceeds chosen threshold.
// - Level shows orange above 0 VU, green above -20 VU, else unlit.
// - Each of eight mixer inputs has gain from -70 dB to +12 dB.
// - Each input feeds the output buses set in its route map.
// - Tied pairs 1/2, 3/4, 5/6, 7/8 share one gain.
// - Invert control negates the sample polarity of an input.
// - Mixer controls split in bank A (channels 1-4) and bank B (5-8).
// - Headphone output carries one of eight channel pairs.
// - Headphone volume scales 0 to 100 percent, 100 after reset.
// - Display monitor output carries one selected channel pair of eight.
module audio_port_mux_mixer_router import audio_router_pkg::*; #(
    parameter int SAMPLE_RATE_HZ = 48000,
    parameter int MAX_DELAY_MS   = 1000,
    parameter int METER_FRAMES   = 4800
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [7:0] awaddr,
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    input  wire logic       wvalid,
    output logic            wready,
    output logic [1:0]      bresp,
    output logic            bvalid,
    input  wire logic       bready,
    input  wire logic [7:0] araddr,
    input  wire logic       arvalid,
    output logic            arready,
    output logic [31:0]     rdata,
    output logic [1:0]      rresp,
    output logic            rvalid,
    input  wire logic       rready,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire emb_frame_t emb_in,
    input  wire ana_frame_t ana_in,
    input  wire logic [3:0] grp_present,
    output logic            out_valid,
    output emb_frame_t      emb_out,
    output ana_frame_t      ana_out,
    output logic [7:0]      ana_dir,
    output logic            ana_ref_hi,
    output pair_t           mon_out,
    output pair_t           disp_out
);
    localparam int SPMS  = SAMPLE_RATE_HZ / 1000;
    localparam int DEPTH = MAX_DELAY_MS * SPMS + 1;

    if (DEPTH > 2 ** DLY_AW || SPMS < 1 || MAX_DELAY_MS > int'(DELAY_MAX_MS)) begin : g_bad_delay
        $error("delay line does not fit");
    end
    if (METER_FRAMES < 1 || METER_FRAMES >= 2 ** MET_W) begin : g_bad_meter
        $error("meter interval out of range");
    end

    state_t s, n;
    logic [NCH*SW-1:0]  dly_mem [DEPTH];
    ana_frame_t         dly_rd;
    ana_frame_t         src_raw;
    logic [DLY_AW-1:0]  dfr, rd_addr;
    logic [7:0]         gsel;
    logic [19:0]        glin;
    logic signed [44:0] prod;
    logic signed [31:0] term;

    function automatic logic [3:0] gain_slot(logic [7:0] a);
        return {a[7:5] == A_GAIN_HI && a[1:0] == 2'h0, a[4:2]};
    endfunction

    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] v, logic [3:0] m);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++)
            if (m[b])
                r[8*b +: 8] = v[8*b +: 8];
        return r;
    endfunction

    function automatic logic [7:0] clamp_db(logic [7:0] d);
        if ($signed(d) < GAIN_MIN_DB)
            return 8'(GAIN_MIN_DB);
        if ($signed(d) > GAIN_MAX_DB)
            return 8'(GAIN_MAX_DB);
        return d;
    endfunction

    // dB to Q16 linear: 6 dB per shift plus fractional table
    function automatic logic [19:0] gain_lin(logic [7:0] d);
        logic [6:0]  u;
        logic [31:0] t;
        u = 7'($signed(d) + 72);
        t = 32'(GAIN_TAB[u % 6]) << (u / 6);
        return 20'(t >> 12);
    endfunction

    function automatic sample_t sat24(logic signed [31:0] v);
        if (v > 32'sh7fffff)
            return 24'h7fffff;
        if (v < -32'sh800000)
            return 24'h800000;
        return v[SW-1:0];
    endfunction

    function automatic sample_t vol_scale(sample_t x, logic [6:0] v);
        logic signed [44:0] p;
        p = x * $signed({1'b0, v}) * $signed({1'b0, VOL_MUL});
        return SW'(p >>> VOL_SHIFT);
    endfunction

    function automatic logic [2:0] slot_stat(logic [2:0] g, logic [3:0] pr);
        if (g == GRP_OFF)
            return STAT_OFF;
        return pr[g[1:0]] ? g + 3'h1 : STAT_NONE;
    endfunction

    function automatic ana_frame_t src_sel(state_t q, emb_frame_t e, ana_frame_t a);
        ana_frame_t r;
        r = '0;
        for (int k = 0; k < 4; k++) begin
            case (q.mode)
                MODE_MUX8: begin
                    r[k]     = a[k];
                    r[4 + k] = a[4 + k];
                end
                MODE_MUX4: begin
                    r[k]     = a[k];
                    r[4 + k] = e[{q.grp_a, 2'(k)}];
                end
                default: begin
                    r[k] = e[{q.grp_a, 2'(k)}];
                    if (q.grp_b != GRP_OFF)
                        r[4 + k] = e[{q.grp_b[1:0], 2'(k)}];
                end
            endcase
        end
        return r;
    endfunction

    function automatic logic [32:0] rd_word(state_t q, logic [7:0] a, logic [3:0] pr);
        logic [31:0] w;
        logic [3:0]  g;
        w = '0;
        g = gain_slot(a);
        if (g[3]) begin
            w[7:0]           = q.gain[g[2:0]];
            w[GN_ROUTE +: 8] = q.route[g[2:0]];
            return {1'b1, w};
        end
        case (a)
            A_CONFIG: begin
                w[CFG_MODE +: 2] = q.mode;
                w[CFG_DREF]      = q.dig_ref;
                w[CFG_PEAK +: 3] = q.peak_sel;
                w[CFG_AREF]      = q.ana_ref;
                w[CFG_GRPA +: 2] = q.grp_a;
                w[CFG_GRPB +: 3] = q.grp_b;
            end
            A_DELAY:
                w[9:0] = q.delay_ms;
            A_STATUS: begin
                w[2:0] = slot_stat({1'b0, q.grp_a}, pr);
                w[5:3] = slot_stat(q.mode == MODE_MUX4 ? GRP_OFF : q.grp_b, pr);
            end
            A_MONITOR: begin
                w[MON_PAIR +: 3] = q.mon_pair;
                w[MON_VOL +: 7]  = q.mon_vol;
                w[MON_DISP +: 3] = q.disp_pair;
            end
            A_LINK: begin
                w[LNK_TIE +: 4] = q.tie;
                w[LNK_INV +: 8] = q.invert;
            end
            A_METER_A:
                w[11:0] = {q.vu_org[3:0], q.vu_grn[3:0], q.peak[3:0]};
            A_METER_B:
                w[11:0] = {q.vu_org[7:4], q.vu_grn[7:4], q.peak[7:4]};
            default:
                return {1'b0, 32'h0};
        endcase
        return {1'b1, w};
    endfunction

    assign src_raw = src_sel(s, emb_in, ana_in);
    assign dfr     = DLY_AW'(s.delay_ms * SPMS);
    assign rd_addr = s.wptr >= dfr ? s.wptr - dfr : DLY_AW'(s.wptr + DEPTH - dfr);
    assign gsel    = (s.ii[0] && s.tie[s.ii[2:1]]) ? s.gain[{s.ii[2:1], 1'b0}] : s.gain[s.ii];
    assign glin    = gain_lin(gsel);
    assign prod    = s.src[s.ii] * $signed({1'b0, glin});
    assign term    = s.invert[s.ii] ? -32'(prod >>> 16) : 32'(prod >>> 16);

    always_comb begin
        logic [31:0]        w;
        logic [32:0]        rw;
        logic [3:0]         g;
        logic signed [31:0] a;
        sample_t            v;
        logic [22:0]        av;
        emb_frame_t         eo;
        ana_frame_t         ao;
        w  = '0;
        rw = '0;
        g  = '0;
        a  = '0;
        v  = '0;
        av = '0;
        eo = s.emb;
        ao = '0;
        n  = s;
        n.out_valid = 1'b0;
        if (s.awready && awvalid) begin
            n.aw_have = 1'b1;
            n.awaddr  = awaddr;
        end
        if (s.wready && wvalid) begin
            n.w_have = 1'b1;
            n.wdata  = wdata;
            n.wstrb  = wstrb;
        end
        if (s.bvalid && bready)
            n.bvalid = 1'b0;
        if (s.aw_have && s.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            rw = rd_word(s, s.awaddr, grp_present);
            n.bresp = rw[32] ? 2'h0 : 2'h2;
            w = merge(rw[31:0], s.wdata, s.wstrb);
            g = gain_slot(s.awaddr);
            if (g[3]) begin
                n.gain[g[2:0]]  = clamp_db(w[7:0]);
                n.route[g[2:0]] = w[GN_ROUTE +: 8];
            end
            case (s.awaddr)
                A_CONFIG: begin
                    if (w[CFG_MODE +: 2] <= MODE_DEMUX)
                        n.mode = w[CFG_MODE +: 2];
                    n.dig_ref = w[CFG_DREF];
                    if (w[CFG_PEAK +: 3] <= 3'h5)
                        n.peak_sel = w[CFG_PEAK +: 3];
                    n.ana_ref = w[CFG_AREF];
                    n.grp_a   = w[CFG_GRPA +: 2];
                    if (w[CFG_GRPB +: 3] <= GRP_OFF)
                        n.grp_b = w[CFG_GRPB +: 3];
                end
                A_DELAY:
                    n.delay_ms = w[9:0] > DELAY_MAX_MS ? DELAY_MAX_MS : w[9:0];
                A_MONITOR: begin
                    n.mon_pair  = w[MON_PAIR +: 3];
                    n.mon_vol   = w[MON_VOL +: 7] > MON_VOL_RST ? MON_VOL_RST : w[MON_VOL +: 7];
                    n.disp_pair = w[MON_DISP +: 3];
                end
                A_LINK: begin
                    n.tie    = w[LNK_TIE +: 4];
                    n.invert = w[LNK_INV +: 8];
                end
                default: ;
            endcase
        end
        if (s.rvalid && rready)
            n.rvalid = 1'b0;
        if (s.arready && arvalid) begin
            rw = rd_word(s, araddr, grp_present);
            n.rvalid = 1'b1;
            n.rdata  = rw[31:0];
            n.rresp  = rw[32] ? 2'h0 : 2'h2;
        end
        n.awready = !n.aw_have;
        n.wready  = !n.w_have;
        n.arready = !n.rvalid;

        case (s.st)
            MS_IDLE:
                if (in_valid) begin
                    n.emb  = emb_in;
                    n.src  = src_raw;
                    n.wptr = s.wptr == DLY_AW'(DEPTH - 1) ? '0 : s.wptr + 1'b1;
                    n.st   = MS_LOAD;
                end
            MS_LOAD: begin
                if (s.delay_ms != '0)
                    n.src = dly_rd;
                n.bi  = '0;
                n.ii  = '0;
                n.acc = '0;
                n.st  = MS_MIX;
            end
            MS_MIX: begin
                a = s.acc + (s.route[s.ii][s.bi] ? term : 32'sh0);
                n.ii = s.ii + 1'b1;
                n.acc = a;
                if (s.ii == 3'h7) begin
                    v = sat24(a);
                    n.bus[s.bi] = v;
                    av = v[SW-1] ? 23'(-v) : v[22:0];
                    if (v == 24'h800000)
                        av = 23'h7fffff;
                    if (av > s.vmax[s.bi])
                        n.vmax[s.bi] = av;
                    n.acc = '0;
                    n.bi  = s.bi + 1'b1;
                    if (s.bi == 3'h7)
                        n.st = MS_OUT;
                end
            end
            MS_OUT: begin
                for (int k = 0; k < 4; k++) begin
                    case (s.mode)
                        MODE_MUX8: begin
                            eo[{s.grp_a, 2'(k)}] = s.bus[k];
                            if (s.grp_b != GRP_OFF)
                                eo[{s.grp_b[1:0], 2'(k)}] = s.bus[4 + k];
                        end
                        MODE_MUX4: begin
                            eo[{s.grp_a, 2'(k)}] = s.bus[k];
                            ao[4 + k] = s.bus[4 + k];
                        end
                        default: begin
                            ao[k]     = s.bus[k];
                            ao[4 + k] = s.bus[4 + k];
                        end
                    endcase
                end
                n.emb_out   = eo;
                n.ana_out   = ao;
                n.mon[0]    = vol_scale(eo[{s.mon_pair, 1'b0}], s.mon_vol);
                n.mon[1]    = vol_scale(eo[{s.mon_pair, 1'b1}], s.mon_vol);
                n.disp[0]   = eo[{s.disp_pair, 1'b0}];
                n.disp[1]   = eo[{s.disp_pair, 1'b1}];
                n.out_valid = 1'b1;
                n.st        = MS_IDLE;
                n.mcnt      = s.mcnt + 1'b1;
                if (s.mcnt == MET_W'(METER_FRAMES - 1)) begin
                    n.mcnt = '0;
                    for (int c = 0; c < NCH; c++) begin
                        n.peak[c]   = s.vmax[c] > PEAK_THR[s.peak_sel];
                        n.vu_org[c] = s.vmax[c] > VU_ORANGE[s.dig_ref];
                        n.vu_grn[c] = s.vmax[c] > VU_GREEN[s.dig_ref] && !n.vu_org[c];
                    end
                    n.vmax = '0;
                end
            end
            default:
                n.st = MS_IDLE;
        endcase
        n.in_ready   = n.st == MS_IDLE;
        n.ana_dir    = s.mode == MODE_MUX8 ? 8'h00 : s.mode == MODE_MUX4 ? 8'hf0 : 8'hff;
        n.ana_ref_hi = s.ana_ref;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s         <= '0;
            s.mon_vol <= MON_VOL_RST;
            s.route   <= ROUTE_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && s.st == MS_IDLE && in_valid) begin
            dly_mem[s.wptr] <= src_raw;
            dly_rd          <= dly_mem[rd_addr];
        end
    end

    assign awready    = s.awready;
    assign wready     = s.wready;
    assign bvalid     = s.bvalid;
    assign bresp      = s.bresp;
    assign arready    = s.arready;
    assign rvalid     = s.rvalid;
    assign rdata      = s.rdata;
    assign rresp      = s.rresp;
    assign in_ready   = s.in_ready;
    assign out_valid  = s.out_valid;
    assign emb_out    = s.emb_out;
    assign ana_out    = s.ana_out;
    assign ana_dir    = s.ana_dir;
    assign ana_ref_hi = s.ana_ref_hi;
    assign mon_out    = s.mon;
    assign disp_out   = s.disp;
endmodule

/* File: sim/audio_router_properties.sv */
`timescale 1ns/1ns
module audio_router_properties import audio_router_pkg::*; (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        awready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic        out_valid,
    input wire ana_frame_t  ana_out,
    input wire logic [7:0]  ana_dir
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic zero_ok;
    always_comb begin
        zero_ok = 1'b1;
        for (int i = 0; i < NCH; i++) begin
            if (!ana_dir[i] && ana_out[i] != '0) begin
                zero_ok = 1'b0;
            end
        end
    end
    sequence s_take;
        in_valid && in_ready && ce;
    endsequence
    sequence s_busy;
        !in_ready [*8];
    endsequence
    a_frame_latency: assert property (s_take |-> ##67 out_valid)
        else $error("frame result late or missing");
    a_busy_after_take: assert property (s_take |=> s_busy)
        else $error("frame accepted while busy");
    a_out_single: assert property (out_valid |=> !out_valid)
        else $error("result pulse longer than one cycle");
    a_out_only_frame: assert property ($changed(ana_out) |-> out_valid)
        else $error("analog output changed outside a frame result");
    a_dir_modes: assert property (ana_dir == 8'h00 || ana_dir == 8'hf0 || ana_dir == 8'hff)
        else $error("port direction pattern not a mode");
    a_input_ports_zero: assert property (out_valid |-> zero_ok)
        else $error("input port shows an output sample");
    a_read_answer: assert property (arvalid && arready && ce |=> rvalid)
        else $error("read answer late");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before taken");
    a_write_done: assert property (bvalid && bready |=> !bvalid && (bresp == 2'h0 || bresp == 2'h2))
        else $error("write response repeated");
endmodule
bind audio_port_mux_mixer_router audio_router_properties u_props (.*);

/* File: sim/audio_stream_peer.sv */
`timescale 1ns/1ns
module audio_stream_peer import audio_router_pkg::*; (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       req,
    input wire emb_frame_t emb_v,
    input wire ana_frame_t ana_v,
    input wire logic       in_ready,
    output logic           in_valid,
    output emb_frame_t     emb_in,
    output ana_frame_t     ana_in
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_valid <= 1'b0;
            emb_in <= '0;
            ana_in <= '0;
        end else if (in_valid && in_ready) begin
            // Released lines no longer show the frame
            in_valid <= 1'b0;
            emb_in <= ~emb_in;
            ana_in <= ~ana_in;
        end else if (req && !in_valid) begin
            in_valid <= 1'b1;
            emb_in <= emb_v;
            ana_in <= ana_v;
        end
    end
endmodule

/* File: sim/tb_audio_port_mux_mixer_router.sv */
`timescale 1ns/1ns
module tb_audio_port_mux_mixer_router import audio_router_pkg::*;;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, req = 1'b0;
    logic [31:0] wdata = '0, rv;
    logic [3:0]  wstrb = 4'hf, grp_present = '0;
    logic [1:0]  rr;
    emb_frame_t  emb_v = '0;
    ana_frame_t  ana_v = '0;
    wire         awready, wready, bvalid, arready, rvalid, in_valid, in_ready, out_valid, ana_ref_hi;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [7:0]   ana_dir;
    emb_frame_t  emb_in, emb_out;
    ana_frame_t  ana_in, ana_out;
    pair_t       mon_out, disp_out;
    int          bad_count = 0, checked = 0, cyc = 0;

    audio_port_mux_mixer_router #(.METER_FRAMES(2)) u_dut (.ce(1'b1), .*);
    audio_stream_peer u_peer (.clock(clock), .rst_n(rst_n), .req(req), .emb_v(emb_v), .ana_v(ana_v),
                              .in_ready(in_ready), .in_valid(in_valid), .emb_in(emb_in), .ana_in(ana_in));

    initial begin
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rr = bresp;
        bready <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        // Late rready keeps the read answer standing a cycle
        @(posedge clock);
        rready <= 1'b1;
        do @(posedge clock); while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(nm, e, rv);
    endtask
    task automatic frame();
        @(posedge clock);
        req <= 1'b1;
        @(posedge clock);
        req <= 1'b0;
        do @(posedge clock); while (!out_valid);
    endtask

    task automatic test_reset();
        rchk("config", A_CONFIG, 32'h0);
        rchk("delay", A_DELAY, 32'h0);
        rchk("monitor", A_MONITOR, 32'h6400);
        rchk("gain1", 8'h20, 32'h100);
        rchk("unmapped", 8'h40, 32'h0);
        chk("unmapped resp", 32'h2, {30'h0, rr});
        wr(8'h40, 32'h1);
        chk("unmapped wr resp", 32'h2, {30'h0, rr});
        chk("dir", 32'hf0, {24'h0, ana_dir});
        chk("aref", 32'h0, {31'h0, ana_ref_hi});
        $display("test_reset done");
    endtask
    task automatic test_config();
        grp_present <= 4'h2;
        wr(A_CONFIG, 32'h41d5);
        rchk("config", A_CONFIG, 32'h41d5);
        chk("dir mux8", 32'h0, {24'h0, ana_dir});
        chk("aref", 32'h1, {31'h0, ana_ref_hi});
        rchk("status", A_STATUS, 32'h2a);
        wr(A_CONFIG, 32'h41d7);
        rchk("bad mode", A_CONFIG, 32'h41d5);
        wr(A_CONFIG, 32'h21d5);
        rchk("status none", A_STATUS, 32'h02);
        $display("test_config done");
    endtask
    task automatic test_demux();
        grp_present <= 4'h3;
        wr(A_CONFIG, 32'h1002);
        chk("dir demux", 32'hff, {24'h0, ana_dir});
        rchk("status", A_STATUS, 32'h11);
        emb_v[0] = 24'h123456;
        emb_v[4] = 24'h0abcde;
        frame();
        chk("ana0", {8'h0, 24'h123456}, {8'h0, ana_out[0]});
        chk("ana4", {8'h0, 24'h0abcde}, {8'h0, ana_out[4]});
        $display("test_demux done");
    endtask
    task automatic test_mix();
        wr(A_CONFIG, 32'h4001);
        wr(A_LINK, 32'h400);
        wr(8'h24, 32'h100);
        ana_v = '0;
        ana_v[0] = 24'h7fffff;
        ana_v[1] = 24'h7fffff;
        ana_v[2] = 24'h000100;
        // Four frames cover a whole two-frame meter interval at any phase
        repeat (4) frame();
        chk("sum sat", {8'h0, 24'h7fffff}, {8'h0, emb_out[0]});
        chk("moved bus", 32'h0, {8'h0, emb_out[1]});
        chk("invert", {8'h0, 24'hffff00}, {8'h0, emb_out[2]});
        chk("input port", 32'h0, {8'h0, ana_out[0]});
        rchk("meter", A_METER_A, 32'h101);
        $display("test_mix done");
    endtask
    task automatic test_tie();
        wr(A_LINK, 32'h1);
        wr(8'h24, 32'h2fa);
        ana_v[0] = 24'h100000;
        ana_v[1] = 24'h100000;
        frame();
        chk("tied pair", {8'h0, 24'h100000}, {8'h0, emb_out[1]});
        wr(8'h2c, 32'h87f);
        rchk("gain max", 8'h2c, 32'h80c);
        wr(8'h2c, 32'h89c);
        rchk("gain min", 8'h2c, 32'h8ba);
        wr(8'h30, 32'h1005);
        rchk("bank b", 8'h30, 32'h1005);
        $display("test_tie done");
    endtask
    task automatic test_misc();
        wr(A_DELAY, 32'h3ff);
        rchk("delay max", A_DELAY, 32'h3e8);
        wr(A_DELAY, 32'h0);
        wr(A_MONITOR, 32'h57f07);
        rchk("monitor", A_MONITOR, 32'h56407);
        emb_v[10] = 24'h123456;
        emb_v[14] = 24'h100000;
        frame();
        chk("headphone", {8'h0, 24'h0ffdc0}, {8'h0, mon_out[0]});
        chk("display", {8'h0, 24'h123456}, {8'h0, disp_out[0]});
        $display("test_misc done");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        test_reset();
        test_config();
        test_demux();
        test_mix();
        test_tie();
        test_misc();
        end_sim();
    end
endmodule
